// ===== plc_pkg.sv
// constants and carrier types for the power-line frame codec
package plc_pkg;

	// ********************
	// frame layout
	// ********************
	localparam logic [3:0] START_PATTERN  = 4'hE;  // raw 1110, msb first on the line
	localparam int         START_BITS     = 4;
	localparam int         HOUSE_BITS     = 4;
	localparam int         KEY_BITS       = 5;
	localparam int         FRAME_LINE_BITS = 22;   // 4 raw + 9 pairs
	localparam int         BLOCK_REPEATS  = 2;
	localparam int         GAP_CROSSINGS  = 6;     // three mains cycles

	// ********************
	// timing
	// ********************
	localparam int CLK_HZ        = 20000000;
	localparam int CARRIER_HZ    = 120000;
	localparam int BURST_US      = 1000;
	localparam int BURST_CYCLES  = CLK_HZ / 1000000 * BURST_US;           // 1 ms
	localparam int CARRIER_HALF  = CLK_HZ / (2 * CARRIER_HZ);             // rounds down
	localparam int SAMPLE_US     = 500;                                   // mid-burst sample
	localparam int SAMPLE_CYCLES = CLK_HZ / 1000000 * SAMPLE_US;
	localparam int PHASE_US      = 2778;                                  // 1/6 of 60 Hz cycle
	localparam int PHASE_CYCLES  = CLK_HZ / 1000000 * PHASE_US;

	// ********************
	// function key codes, weight-sixteen bit first
	// ********************
	localparam logic [4:0] KEY_DIM    = 5'h12;  // key 01001 as d1..d16
	localparam logic [4:0] KEY_BRIGHT = 5'h1A;  // key 01011 as d1..d16

	// request to send one frame
	typedef struct packed {
		logic [3:0] house;   // house_weight_one .. eight, index 0 = weight one
		logic [4:0] key;     // key_weight_one .. key_type_suffix, index 4 = suffix
	} plc_msg_t;

	// decoded frame
	typedef struct packed {
		logic       is_command;
		logic [3:0] house;
		logic [4:0] key;
	} plc_rx_t;

endpackage : plc_pkg

// ===== plc_frame_codec.sv
// power-line home frame encoder and decoder, one bit per zero-crossing
// Operation
// RL1 - one line bit per mains zero-crossing, for send and receive
// RL2 - one is a 1 ms 120 kHz burst, zero is no burst
// RL3 - with phase option, repeat bursts at other phases' crossings
// RL4 - frame opens with raw 1110, then house, then key
// RL5 - house letters are four weighted bits, weight one first
// RL6 - unit keys are five bits, suffix bit zero
// RL7 - function keys have suffix bit set
// RL8 - each house and key bit goes as a complementary pair
// RL9 - receiver finds frame start by raw 1110
// RL10 - suffix bit tells address from command, reported on receive
// RL11 - block is start, house pairs, key pairs, suffix pair in order
// RL12 - every block sent twice, then six empty crossings
// RL13 - address pair, gap, command pair, gap, for unit switching
// RL14 - no gap between consecutive dim or consecutive bright commands
// RL15 - unit sixteen key is 11000, caller supplies it
// RL16 - non-complementary pair discards frame and hunts again
// RL17 - busy during pair and gap; receive flag with type
`timescale 1ns/1ps
module plc_frame_codec (
	// clock and reset
	input  wire logic             CLK_IN,
	input  wire logic             RST_N_IN,
	// line front end
	input  wire logic             ZERO_CROSS_IN,
	input  wire logic             CARRIER_DET_IN,
	output logic                  CARRIER_OUT,
	// options
	input  wire logic             PHASE3_EN_IN,
	// send request
	input  wire logic             TX_VALID_IN,
	input  wire plc_pkg::plc_msg_t TX_MSG_IN,
	output logic                  TX_READY_OUT,
	output logic                  TX_BUSY_OUT,
	// receive report
	output logic                  RX_VALID_OUT,
	output plc_pkg::plc_rx_t      RX_MSG_OUT
);

	// ********************
	// input synchronisers and crossing edge
	// ********************
	logic [1:0] zc_sync;
	logic [1:0] cd_sync;
	logic       zc_last;
	logic       zc_edge;

	// two flops per pin before use
	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			zc_sync <= 2'h0;
			cd_sync <= 2'h0;
			zc_last <= 1'b0;
		end
		else
		begin
			zc_sync <= {zc_sync[0], ZERO_CROSS_IN};
			cd_sync <= {cd_sync[0], CARRIER_DET_IN};
			zc_last <= zc_sync[1];
		end
	end

	// RL1 crossing strobe
	// detector toggles at each crossing, so both edges count
	assign zc_edge = zc_sync[1] ^ zc_last;

	// ********************
	// transmit sequencer
	// ********************
	typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND, TX_GAP} tx_state_t;
	tx_state_t  tx_state;
	logic [21:0] tx_shift;
	logic [4:0] tx_count;
	logic       tx_rep;
	logic [4:0] last_key;
	logic       tx_bit;
	logic [21:0] next_frame;
	logic       repeat_ok;

	// RL4 RL11 build raw start then pairs in order
	// RL8 complementary pairs from each bit
	// RL5 RL6 RL7 RL15 caller codes sent as given
	always_comb
	begin
		next_frame = {plc_pkg::START_PATTERN, 18'h0};
		for (int i = 0; i < 4; i++)
			next_frame[17 - 2*i -: 2] = TX_MSG_IN.house[i] ? 2'h2 : 2'h1;
		for (int i = 0; i < 5; i++)
			next_frame[9 - 2*i -: 2] = TX_MSG_IN.key[i] ? 2'h2 : 2'h1;
	end

	// RL14 same dim or bright key asked again
	// last_key holds the key of the pair now on the line
	assign repeat_ok = TX_VALID_IN && TX_MSG_IN.key == last_key
		&& (last_key == plc_pkg::KEY_DIM || last_key == plc_pkg::KEY_BRIGHT);

	assign TX_READY_OUT = (tx_state == TX_IDLE);
	// RL17 busy through pair and gap
	assign TX_BUSY_OUT  = (tx_state != TX_IDLE);

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			tx_state   <= TX_IDLE;
			tx_shift   <= 22'h0;
			tx_count   <= 5'h0;
			tx_rep     <= 1'b0;
			tx_bit     <= 1'b0;
			last_key   <= 5'h0;
		end
		else
		begin
			tx_bit <= 1'b0;
			unique case (tx_state)
				TX_IDLE:
				begin
					if (TX_VALID_IN)
					begin
						tx_shift <= next_frame;
						tx_count <= 5'(plc_pkg::FRAME_LINE_BITS);
						tx_rep   <= 1'b0;
						last_key <= TX_MSG_IN.key;
						tx_state <= TX_WAIT;
					end
				end
				TX_WAIT:
				begin
					// RL1 wait for crossing before first bit
					if (zc_edge)
					begin
						tx_bit   <= tx_shift[21];
						tx_shift <= {tx_shift[20:0], tx_shift[21]};
						tx_count <= tx_count - 5'h1;
						tx_state <= TX_SEND;
					end
				end
				TX_SEND:
				begin
					if (zc_edge)
					begin
						if (tx_count != 5'h0)
						begin
							tx_bit   <= tx_shift[21];
							tx_shift <= {tx_shift[20:0], tx_shift[21]};
							tx_count <= tx_count - 5'h1;
						end
						// RL12 second copy straight after the first
						else if (!tx_rep)
						begin
							tx_rep   <= 1'b1;
							tx_bit   <= tx_shift[21];
							tx_shift <= {tx_shift[20:0], tx_shift[21]};
							tx_count <= 5'(plc_pkg::FRAME_LINE_BITS - 1);
						end
						// RL14 dim after dim or bright after bright: first bit on this crossing
						else if (repeat_ok)
						begin
							tx_rep   <= 1'b0;
							tx_bit   <= next_frame[21];
							tx_shift <= {next_frame[20:0], next_frame[21]};
							tx_count <= 5'(plc_pkg::FRAME_LINE_BITS - 1);
						end
						else
						begin
							// this crossing is already the first of the six empty ones
							tx_count <= 5'(plc_pkg::GAP_CROSSINGS - 2);
							tx_state <= TX_GAP;
						end
					end
				end
				TX_GAP:
				begin
					// RL12 RL13 six empty crossings end the pair
					if (zc_edge)
					begin
						if (tx_count == 5'h0)
							tx_state <= TX_IDLE;
						else
							tx_count <= tx_count - 5'h1;
					end
				end
			endcase
		end
	end

	// ********************
	// burst generator
	// ********************
	logic [14:0] burst_timer;
	logic [16:0] phase_timer;
	logic [1:0]  phase_left;
	logic [6:0]  carrier_div;

	// RL2 1 ms burst gated 120 kHz square wave
	// RL3 optional bursts at the two other phase crossings
	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			burst_timer <= 15'h0;
			phase_timer <= 17'h0;
			phase_left  <= 2'h0;
			carrier_div <= 7'h0;
			CARRIER_OUT <= 1'b0;
		end
		else
		begin
			if (tx_bit)
			begin
				burst_timer <= 15'(plc_pkg::BURST_CYCLES);
				phase_timer <= 17'(plc_pkg::PHASE_CYCLES);
				phase_left  <= PHASE3_EN_IN ? 2'h2 : 2'h0;
			end
			else
			begin
				if (burst_timer != 15'h0)
					burst_timer <= burst_timer - 15'h1;
				if (phase_left != 2'h0)
				begin
					if (phase_timer == 17'h0)
					begin
						burst_timer <= 15'(plc_pkg::BURST_CYCLES);
						phase_timer <= 17'(plc_pkg::PHASE_CYCLES);
						phase_left  <= phase_left - 2'h1;
					end
					else
						phase_timer <= phase_timer - 17'h1;
				end
			end
			if (burst_timer == 15'h0)
			begin
				carrier_div <= 7'h0;
				CARRIER_OUT <= 1'b0;
			end
			else if (carrier_div == 7'(plc_pkg::CARRIER_HALF - 1))
			begin
				carrier_div <= 7'h0;
				CARRIER_OUT <= ~CARRIER_OUT;
			end
			else
				carrier_div <= carrier_div + 7'h1;
		end
	end

	// ********************
	// receiver
	// ********************
	logic [14:0] samp_timer;
	logic        samp_arm;
	logic        rx_bit_stb;
	logic        rx_bit;
	logic [3:0]  hunt;
	logic        rx_in_frame;
	logic [4:0]  rx_cnt;
	logic [17:0] rx_pairs;

	// RL1 sample detector mid-slot after each crossing
	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			samp_timer <= 15'h0;
			samp_arm   <= 1'b0;
			rx_bit_stb <= 1'b0;
			rx_bit     <= 1'b0;
		end
		else
		begin
			rx_bit_stb <= 1'b0;
			if (zc_edge)
			begin
				samp_timer <= 15'(plc_pkg::SAMPLE_CYCLES);
				samp_arm   <= 1'b1;
			end
			else if (samp_arm && samp_timer == 15'h0)
			begin
				samp_arm   <= 1'b0;
				rx_bit_stb <= 1'b1;
				rx_bit     <= cd_sync[1];
			end
			else if (samp_timer != 15'h0)
				samp_timer <= samp_timer - 15'h1;
		end
	end

	always_ff @(posedge CLK_IN)
	begin
		if (!RST_N_IN)
		begin
			hunt         <= 4'h0;
			rx_in_frame  <= 1'b0;
			rx_cnt       <= 5'h0;
			rx_pairs     <= 18'h0;
			RX_VALID_OUT <= 1'b0;
			RX_MSG_OUT   <= '0;
		end
		else
		begin
			RX_VALID_OUT <= 1'b0;
			if (rx_bit_stb)
			begin
				hunt <= {hunt[2:0], rx_bit};
				if (!rx_in_frame)
				begin
					// RL9 resync on raw start
					if ({hunt[2:0], rx_bit} == plc_pkg::START_PATTERN)
					begin
						rx_in_frame <= 1'b1;
						rx_cnt      <= 5'h0;
					end
				end
				else
				begin
					rx_pairs <= {rx_pairs[16:0], rx_bit};
					rx_cnt   <= rx_cnt + 5'h1;
					// RL16 bad pair drops the frame
					if (rx_cnt[0] && (rx_pairs[0] == rx_bit))
					begin
						rx_in_frame <= 1'b0;
						hunt        <= 4'h0;
					end
					else if (rx_cnt == 5'h11)
					begin
						rx_in_frame <= 1'b0;
						hunt        <= 4'h0;
						RX_VALID_OUT <= 1'b1;
						// RL10 suffix sets the reported type
						RX_MSG_OUT.is_command <= rx_pairs[0];
						for (int i = 0; i < 4; i++)
							RX_MSG_OUT.house[i] <= rx_pairs[16 - 2*i];
						for (int i = 0; i < 4; i++)
							RX_MSG_OUT.key[i] <= rx_pairs[8 - 2*i];
						RX_MSG_OUT.key[4] <= rx_pairs[0];
					end
				end
			end
		end
	end

	// ********************
	// checks
	// ********************
	property p_busy_start;
		@(posedge CLK_IN) disable iff (!RST_N_IN) $rose(TX_BUSY_OUT) |-> $past(TX_VALID_IN);
	endproperty
	a_busy_start: assert property (p_busy_start) else $error("busy without request"); // RL17

	property p_bit_on_crossing;
		@(posedge CLK_IN) disable iff (!RST_N_IN) tx_bit |-> $past(zc_edge);
	endproperty
	a_bit_on_crossing: assert property (p_bit_on_crossing) else $error("bit off crossing"); // RL1

	property p_burst_len;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
			tx_bit |=> (burst_timer == 15'(plc_pkg::BURST_CYCLES))
			##1 (burst_timer == 15'(plc_pkg::BURST_CYCLES - 1));
	endproperty
	a_burst_len: assert property (p_burst_len) else $error("burst ended early"); // RL2

	property p_no_burst_idle;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
			(tx_state == TX_IDLE && burst_timer == 15'h0) |=> !CARRIER_OUT;
	endproperty
	a_no_burst_idle: assert property (p_no_burst_idle) else $error("carrier when idle"); // RL2

	property p_frame_start;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
			(tx_state == TX_WAIT && zc_edge && !tx_rep) |=> tx_bit;
	endproperty
	a_frame_start: assert property (p_frame_start) else $error("frame not opened by one"); // RL4

	property p_gap_quiet;
		@(posedge CLK_IN) disable iff (!RST_N_IN) (tx_state == TX_GAP) |-> !tx_bit;
	endproperty
	a_gap_quiet: assert property (p_gap_quiet) else $error("burst in gap"); // RL12

	property p_rx_type;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
			RX_VALID_OUT |-> (RX_MSG_OUT.is_command != $past(rx_bit))
				&& (RX_MSG_OUT.key[4] != $past(rx_bit));
	endproperty
	a_rx_type: assert property (p_rx_type) else $error("type and suffix differ"); // RL10

	property p_rx_pulse;
		@(posedge CLK_IN) disable iff (!RST_N_IN) RX_VALID_OUT |=> !RX_VALID_OUT;
	endproperty
	a_rx_pulse: assert property (p_rx_pulse) else $error("receive flag too long"); // RL17

	property p_bad_pair;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
			(rx_bit_stb && rx_in_frame && rx_cnt[0] && rx_pairs[0] == rx_bit)
			|=> !rx_in_frame && !RX_VALID_OUT;
	endproperty
	a_bad_pair: assert property (p_bad_pair) else $error("bad pair kept"); // RL16

	property p_repeat_direct;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
			(tx_state == TX_SEND && zc_edge && tx_count == 5'h0 && tx_rep && repeat_ok)
			|=> tx_bit && tx_state == TX_SEND && !tx_rep;
	endproperty
	a_repeat_direct: assert property (p_repeat_direct) else $error("repeat not direct"); // RL14

	c_send: cover property (@(posedge CLK_IN) tx_state == TX_GAP);
	c_recv_cmd: cover property (@(posedge CLK_IN) RX_VALID_OUT && RX_MSG_OUT.is_command);
	c_recv_addr: cover property (@(posedge CLK_IN) RX_VALID_OUT && !RX_MSG_OUT.is_command);
	c_repeat: cover property (@(posedge CLK_IN) tx_state == TX_SEND && zc_edge && repeat_ok);

endmodule : plc_frame_codec

// ===== plc_line_model.sv
// power-line partner: crossing source, carrier detector and burst monitor
`timescale 1ns/1ps
module plc_line_model (
	// line front end
	output logic      ZERO_CROSS_OUT,
	output logic      CARRIER_DET_OUT,
	input  wire logic CARRIER_IN
);
	// ********************
	// line state
	// ********************
	logic q_bits[$];  // bits still to send
	logic slot_bit;   // carrier seen in last slot
	int   slot_edges; // carrier edges in last slot
	event slot_done;

	// count carrier edges, cleared at each crossing
	always @(CARRIER_IN)
		slot_edges++;

	// crossings 1.05 ms apart, so a 1 ms burst fits each slot
	// slot and burst
	initial
	begin
		ZERO_CROSS_OUT = 1'h0;
		CARRIER_DET_OUT = 1'h0;
		slot_bit = 1'h0;
		#1013;
		forever
		begin
			ZERO_CROSS_OUT = ~ZERO_CROSS_OUT;
			slot_edges = 0;
			CARRIER_DET_OUT = (q_bits.size() > 0) ? q_bits.pop_front() : 1'h0;
			#1000000 CARRIER_DET_OUT = 1'h0;
			#40000 slot_bit = (slot_edges > 0);
			-> slot_done;
			#10000;
		end
	end
endmodule : plc_line_model

// ===== plc_frame_codec_tb.sv
// self-checking bench for the power-line frame codec
`timescale 1ns/1ps
module plc_frame_codec_tb;
	// ********************
	// wiring and bookkeeping
	// ********************
	localparam int     EDGES = plc_pkg::BURST_CYCLES / plc_pkg::CARRIER_HALF;
	logic              clk = 1'h0;
	logic              rst_n = 1'h0;
	logic              zero_cross;
	logic              carrier_det;
	logic              carrier;
	logic              tx_valid = 1'h0;
	plc_pkg::plc_msg_t tx_msg = '0;
	logic              tx_ready;
	logic              tx_busy;
	logic              rx_valid;
	plc_pkg::plc_rx_t  rx_msg;
	int                fails = 0;
	int                checked = 0;
	logic [31:0]       seed = 32'h11;
	logic [1:0]        exp_slot[$]; // {line bit, busy} per crossing
	plc_pkg::plc_rx_t  exp_rx[$];
	logic              armed = 1'h0;
	plc_pkg::plc_msg_t addr;
	plc_pkg::plc_msg_t cmd;
	logic [21:0]       bits;
	int                n;

	// 20 MHz clock
	always #25 clk = ~clk;

	plc_frame_codec dut (
		.CLK_IN         (clk),
		.RST_N_IN       (rst_n),
		.ZERO_CROSS_IN  (zero_cross),
		.CARRIER_DET_IN (carrier_det),
		.CARRIER_OUT    (carrier),
		.PHASE3_EN_IN   (1'h0),
		.TX_VALID_IN    (tx_valid),
		.TX_MSG_IN      (tx_msg),
		.TX_READY_OUT   (tx_ready),
		.TX_BUSY_OUT    (tx_busy),
		.RX_VALID_OUT   (rx_valid),
		.RX_MSG_OUT     (rx_msg)
	);

	plc_line_model line (
		.ZERO_CROSS_OUT  (zero_cross),
		.CARRIER_DET_OUT (carrier_det),
		.CARRIER_IN      (carrier)
	);

	// ********************
	// helpers
	// ********************
	// xorshift source, seeded at 17
	function automatic logic [31:0] next_rand(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction : next_rand

	function automatic logic [21:0] line_of(input plc_pkg::plc_msg_t m);
		logic [21:0] v;
		logic [8:0]  f;
		f = {m.key, m.house};
		v = {plc_pkg::START_PATTERN, 18'h0};
		for (int i = 0; i < 9; i++)
		begin
			v[17 - 2 * i] = f[i];
			v[16 - 2 * i] = ~f[i];
		end
		return v;
	endfunction : line_of

	// queue line bits for the partner, msb first
	task automatic put_line(input logic [21:0] v, input int len);
		for (int i = 0; i < len; i++)
			line.q_bits.push_back(v[21 - i]);
	endtask : put_line

	task automatic miss(input logic [15:0] got, input logic [15:0] exp);
		fails++;
		$display("ERROR %0t got %h exp %h", $time, got, exp);
	endtask : miss

	task automatic chk_slot(input logic [1:0] got, input logic [1:0] exp);
		checked++;
		if (got !== exp)
			miss({14'h0, got}, {14'h0, exp});
	endtask : chk_slot

	task automatic chk_rx(input plc_pkg::plc_rx_t got, input plc_pkg::plc_rx_t exp);
		checked++;
		if (got !== exp)
			miss({6'h0, got}, {6'h0, exp});
	endtask : chk_rx

	task automatic chk_flag(input logic got, input logic exp);
		checked++;
		if (got !== exp)
			miss({15'h0, got}, {15'h0, exp});
	endtask : chk_flag

	task automatic results;
		if (fails == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	// ********************
	// watchers
	// ********************
	// one note per crossing once the send is armed
	always @(line.slot_done)
	begin
		if (armed && exp_slot.size() > 0)
			chk_slot({line.slot_bit, tx_busy}, exp_slot.pop_front());
		if (armed && line.slot_bit === 1'h1)
			chk_flag(line.slot_edges >= EDGES - 1 && line.slot_edges <= EDGES + 2, 1'h1);
	end

	// sampled mid-cycle so the registered pulse has settled
	always @(negedge clk)
		if (rx_valid === 1'h1)
			chk_rx(rx_msg, exp_rx.size() > 0 ? exp_rx.pop_front() : 'x);

	// ********************
	// main sequence
	// ********************
	initial
	begin
		repeat (2) @(posedge clk);
		#2 rst_n = 1'h1;
		@(posedge clk);
		#2;
		chk_flag(tx_ready & ~tx_busy & ~rx_valid & ~carrier, 1'h1);
		seed = next_rand(seed);
		addr = {seed[3:0], 1'h0, seed[7:4]};
		cmd = {seed[11:8], 1'h1, seed[15:12]};
		// address pair, gap, command pair, gap; first copy damaged
		bits = line_of(addr);
		bits[17:16] = 2'h0;
		put_line(bits, 22);
		put_line(line_of(addr), 22);
		put_line(22'h0, 6);
		put_line(line_of(cmd), 22);
		put_line(line_of(cmd), 22);
		put_line(22'h0, 6);
		exp_rx.push_back({1'h0, addr});
		exp_rx.push_back({1'h1, cmd});
		exp_rx.push_back({1'h1, cmd});
		// house A dim held on: two pairs back to back, then six empty slots
		tx_msg = {4'h6, plc_pkg::KEY_DIM};
		bits = line_of(tx_msg);
		for (int i = 0; i < 94; i++)
			exp_slot.push_back({(i < 88) ? bits[21 - i % 22] : 1'h0, i < 93});
		tx_valid = 1'h1;
		@(posedge clk);
		#2;
		chk_flag(tx_busy, 1'h1);
		@(zero_cross);
		#1 armed = 1'h1;
		n = 0;
		while ((exp_slot.size() > 0 || exp_rx.size() > 0) && n < 120)
		begin
			@(line.slot_done);
			n++;
			// repeat taken at crossing 45, so drop the request before the second pair ends
			if (n == 45)
			begin
				@(posedge clk);
				#2 tx_valid = 1'h0;
			end
		end
		if (n >= 120)
			fails++;
		repeat (8) @(line.slot_done);
		chk_flag(tx_ready, 1'h1);
		results;
	end
endmodule : plc_frame_codec_tb
